// file: ptc_trigger_ctrl.v
// trigger output control slice: registers, cascade chaining, notification
// Functional notes
// - chain-mode bit joins unit into cascade chain
// - tail bit marks last unit of chain
// - two-bit selector picks upstream done unit
// - trigger-now fires at once if target past
// - target not past: wait until target time reached
// - notify on: report flags, raise enabled interrupt
// - notify off: suppress done and fault flags
// - edge bit selects falling or rising launch
// - control register addressed by global unit index
// - enable self-clears on fire; enable head only
// - soft clear returns unit to defaults, idle
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "ptc_consts.vh"

module ptc_trigger_ctrl #(
    parameter UNITS = 4
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire [15:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    output reg [31:0] reg_rdata_o,
    input wire [3:0] time_due_i,
    input wire [3:0] time_past_i,
    output wire [3:0] trig_o,
    output wire irq_o
);

    reg [1:0] unit_index;
    reg [3:0] done_flag;
    reg [3:0] fault_flag;
    reg [7:0] irq_enable;
    wire [6:0] ctl_w [0:3];
    wire [3:0] enable_w;
    wire [3:0] fire_w;
    wire [3:0] fault_w;
    wire [3:0] busy_w;
    wire [3:0] chain_w;
    wire [3:0] tail_w;
    wire [3:0] notify_w;
    reg [31:0] next_rdata;
    wire wr_ctl = reg_write_i && (reg_addr_i == `PTC_CONTROL_ONE_ADDR);
    wire wr_cmd = reg_write_i && (reg_addr_i == `PTC_UNIT_CMD_ADDR);
    wire wr_stat = reg_write_i && (reg_addr_i == `PTC_NOTIFY_STAT_ADDR);
    wire wr_idx = reg_write_i && (reg_addr_i == `PTC_UNIT_INDEX_ADDR);
    wire wr_irq = reg_write_i && (reg_addr_i == `PTC_IRQ_ENABLE_ADDR);
    wire cmd_clear = reg_wdata_i[`PTC_CMD_SOFT_CLEAR_BIT];
    wire cmd_enable = reg_wdata_i[`PTC_CMD_ENABLE_BIT];

    // ****************************************
    // global index and interrupt enable
    // ****************************************
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unit_index <= `PTC_INDEX_RESET;
            irq_enable <= 8'h00;
        end else begin
            if (wr_idx) begin
                unit_index <= reg_wdata_i[1:0];
            end
            if (wr_irq) begin
                irq_enable <= reg_wdata_i[7:0];
            end
        end
    end

    // ****************************************
    // per-unit control and cascade
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < UNITS; g = g + 1) begin : g_unit
            reg [6:0] ctl;
            reg en;
            wire sel_me = ({30'h0, unit_index} == g);
            wire clr = wr_cmd && sel_me && cmd_clear;
            wire arm = wr_cmd && sel_me && cmd_enable && !clr;
            wire chain_on = chain_w[g];
            wire [1:0] up_sel = ctl[4:3];
            wire now_on = ctl[2];
            wire edge_on = ctl[0];
            // selecting itself means no upstream
            wire self_up = ({30'h0, up_sel} == g);
            // a tail's done does not feed back, so a chain with a tail stops
            wire up_done = chain_on && !self_up && fire_w[up_sel] && !tail_w[up_sel];
            // only an idle, unarmed unit takes a software start
            wire arm_start = arm && !en && !busy_w[g];
            wire start = arm_start || up_done;

            always @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    ctl <= `PTC_CTL_RESET;
                    en <= 1'b0;
                end else begin
                    if (clr) begin
                        ctl <= `PTC_CTL_RESET;
                        en <= 1'b0;
                    end else begin
                        if (wr_ctl && sel_me) begin
                            // bits 29:28 never stored
                            ctl <= {reg_wdata_i[`PTC_CHAIN_ON_BIT],
                                    reg_wdata_i[`PTC_TAIL_BIT],
                                    reg_wdata_i[`PTC_UPSEL_HI:`PTC_UPSEL_LO],
                                    reg_wdata_i[`PTC_NOW_BIT],
                                    reg_wdata_i[`PTC_NOTIFY_BIT],
                                    reg_wdata_i[`PTC_EDGE_BIT]};
                        end
                        if (fire_w[g] || fault_w[g]) begin
                            en <= 1'b0;
                        end else if (arm) begin
                            en <= 1'b1;
                        end
                    end
                end
            end

            assign ctl_w[g] = ctl;
            assign enable_w[g] = en;
            assign chain_w[g] = ctl[6];
            assign tail_w[g] = ctl[5];
            assign notify_w[g] = ctl[1];

            ptc_fire_unit u_fire (
                .sys_clk_i(sys_clk_i),
                .reset_n_i(reset_n_i),
                .start_i(start),
                .soft_clear_i(clr),
                .now_i(now_on),
                .edge_i(edge_on),
                .due_i(time_due_i[g]),
                .past_i(time_past_i[g]),
                .fire_o(fire_w[g]),
                .fault_o(fault_w[g]),
                .busy_o(busy_w[g]),
                .trig_o(trig_o[g])
            );
        end
    endgenerate

    // ****************************************
    // notification flags
    // ****************************************
    // set wins over a same-cycle write-one clear
    wire [3:0] done_clr = wr_stat ? reg_wdata_i[`PTC_DONE_LO+3:`PTC_DONE_LO] : 4'h0;
    wire [3:0] fault_clr = wr_stat ? reg_wdata_i[`PTC_FAULT_LO+3:`PTC_FAULT_LO] : 4'h0;
    wire [3:0] done_set = fire_w & notify_w;
    wire [3:0] fault_set = fault_w & notify_w;

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_flag <= 4'h0;
            fault_flag <= 4'h0;
        end else begin
            done_flag <= (done_flag & ~done_clr) | done_set;
            fault_flag <= (fault_flag & ~fault_clr) | fault_set;
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    // level output, drops as soon as software clears the flag
    assign irq_o = |({fault_flag, done_flag} & irq_enable);

    // ****************************************
    // selected unit view
    // ****************************************
    wire [6:0] sel_ctl = ctl_w[unit_index];
    wire sel_busy = busy_w[unit_index];
    wire sel_en = enable_w[unit_index];
    // bits 29:28 are never stored, so they read zero
    wire [31:0] ctl_word = {sel_ctl[6:5], 2'h0, sel_ctl[4:0], 23'h0};
    wire [31:0] cmd_word = {27'h0, sel_busy, sel_en, 3'h0};
    wire [31:0] stat_word = {24'h0, fault_flag, done_flag};
    wire [31:0] idx_word = {30'h0, unit_index};
    wire [31:0] irq_word = {24'h0, irq_enable};

    // ****************************************
    // read back
    // ****************************************
    // unmapped addresses and idle cycles read zero
    always @* begin
        next_rdata = 32'h00000000;
        if (reg_read_i) begin
            case (reg_addr_i)
                `PTC_UNIT_INDEX_ADDR: begin
                    next_rdata = idx_word;
                end
                `PTC_UNIT_CMD_ADDR: begin
                    next_rdata = cmd_word;
                end
                `PTC_NOTIFY_STAT_ADDR: begin
                    next_rdata = stat_word;
                end
                `PTC_IRQ_ENABLE_ADDR: begin
                    next_rdata = irq_word;
                end
                `PTC_CONTROL_ONE_ADDR: begin
                    next_rdata = ctl_word;
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule // ptc_trigger_ctrl

// file: ptc_consts.vh
// constants for the trigger output control slice
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

// register byte addresses
`define PTC_ADDR_W 16
`define PTC_UNIT_INDEX_ADDR 16'h0500
`define PTC_UNIT_CMD_ADDR 16'h0504
`define PTC_NOTIFY_STAT_ADDR 16'h0508
`define PTC_IRQ_ENABLE_ADDR 16'h050C
`define PTC_CONTROL_ONE_ADDR 16'h0538

// control one field positions
`define PTC_CHAIN_ON_BIT 31
`define PTC_TAIL_BIT 30
`define PTC_UPSEL_HI 27
`define PTC_UPSEL_LO 26
`define PTC_NOW_BIT 25
`define PTC_NOTIFY_BIT 24
`define PTC_EDGE_BIT 23

// unit command register field positions
`define PTC_CMD_ACTIVE_BIT 4
`define PTC_CMD_ENABLE_BIT 3
`define PTC_CMD_SOFT_CLEAR_BIT 2

// notify status layout: done flags low nibble, fault flags next nibble
`define PTC_DONE_LO 0
`define PTC_FAULT_LO 4

// reset values
`define PTC_CTL_RESET 7'h00
`define PTC_INDEX_RESET 2'h0

// unit states
`define PTC_ST_IDLE 1'b0
`define PTC_ST_WAIT 1'b1

`endif

// file: ptc_fire_unit.v
// one trigger output unit: arm, wait for target time, fire
`timescale 1ns/100ps
`include "ptc_consts.vh"

module ptc_fire_unit (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire start_i,
    input wire soft_clear_i,
    input wire now_i,
    input wire edge_i,
    input wire due_i,
    input wire past_i,
    output wire fire_o,
    output wire fault_o,
    output wire busy_o,
    output wire trig_o
);

    reg state;
    reg next_state;
    reg fire_q;
    reg fault_q;
    reg next_fire;
    reg next_fault;
    reg neg_q;

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    // ****************************************
    // sequencing
    // ****************************************
    always @* begin
        next_state = state;
        next_fire = 1'b0;
        next_fault = 1'b0;
        case (state)
            ST_IDLE: begin
                if (start_i) begin
                    if (past_i && now_i) begin
                        next_fire = 1'b1;
                    end else if (past_i) begin
                        // a missed target is a fault, not a late pulse
                        next_fault = 1'b1;
                    end else begin
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (due_i) begin
                    next_fire = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (soft_clear_i) begin
            next_state = ST_IDLE;
            next_fire = 1'b0;
            next_fault = 1'b0;
        end
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            fire_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            state <= next_state;
            fire_q <= next_fire;
            fault_q <= next_fault;
        end
    end

    // ****************************************
    // output launch edge
    // ****************************************
    // half-cycle late copy for falling-edge launch
    always @(negedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= fire_q;
        end
    end

    assign trig_o = edge_i ? neg_q : fire_q;
    assign fire_o = fire_q;
    assign fault_o = fault_q;
    assign busy_o = (state == ST_WAIT);

endmodule // ptc_fire_unit

// file: ptc_trigger_ctrl_monitor.sv
// checker for the trigger output control slice
`timescale 1ns/100ps
module ptc_trigger_ctrl_monitor (
    input logic sys_clk_i,
    input logic reset_n_i,
    input logic [15:0] reg_addr_i,
    input logic reg_read_i,
    input logic [31:0] reg_rdata_o,
    input logic [3:0] time_due_i,
    input logic [3:0] trig_o,
    input logic irq_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_idle; !$past(reg_read_i) |-> reg_rdata_o == 32'h0; endproperty
    property p_rsv; $past(reg_read_i) && $past(reg_addr_i) == 16'h0538
        |-> reg_rdata_o[29:28] == 2'h0; endproperty
    property p_unmap; $past(reg_read_i) && $past(reg_addr_i) == 16'h0600
        |-> reg_rdata_o == 32'h0; endproperty
    property p_idx; $past(reg_read_i) && $past(reg_addr_i) == 16'h0500
        |-> reg_rdata_o[31:2] == 30'h0; endproperty
    property p_cmd; $past(reg_read_i) && $past(reg_addr_i) == 16'h0504
        |-> reg_rdata_o[31:5] == 27'h0 && !reg_rdata_o[2]; endproperty
    property p_stat; $past(reg_read_i) && $past(reg_addr_i) == 16'h0508
        |-> reg_rdata_o[31:8] == 24'h0; endproperty
    property p_pulse; trig_o != 4'h0 |=> (trig_o & $past(trig_o)) == 4'h0; endproperty
    // a fire never comes without the target time having been reached
    property p_cause; (trig_o & ~$past(trig_o) & ~$past(time_due_i)
        & ~$past(time_due_i, 2)) == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero when idle");
    a_rsv: assert property (p_rsv) else $error("reserved bits read non zero");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_idx: assert property (p_idx) else $error("index read too wide");
    a_cmd: assert property (p_cmd) else $error("soft clear bit reads back");
    a_stat: assert property (p_stat) else $error("status read too wide");
    a_pulse: assert property (p_pulse) else $error("trigger longer than one cycle");
    a_cause: assert property (p_cause) else $error("trigger before target time");
    c_fire: cover property ($rose(trig_o[3]));
    c_irq: cover property ($rose(irq_o));
    c_ctl: cover property (reg_read_i && reg_addr_i == 16'h0538);
endmodule // ptc_trigger_ctrl_monitor

bind ptc_trigger_ctrl ptc_trigger_ctrl_monitor u_mon (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o),
    .time_due_i(time_due_i),
    .trig_o(trig_o),
    .irq_o(irq_o)
);

// file: ptc_trigger_ctrl_test.sv
// self-checking bench for the trigger output control slice
`timescale 1ns/100ps
`include "ptc_consts.vh"
module ptc_trigger_ctrl_test;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [3:0] time_due_i = 4'h0;
    logic [3:0] time_past_i = 4'h0;
    wire [31:0] reg_rdata_o;
    wire [3:0] trig_o;
    wire irq_o;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int pc [4];
    localparam logic [15:0] IDX = `PTC_UNIT_INDEX_ADDR;
    localparam logic [15:0] CMD = `PTC_UNIT_CMD_ADDR;
    localparam logic [15:0] STA = `PTC_NOTIFY_STAT_ADDR;
    localparam logic [15:0] CTL = `PTC_CONTROL_ONE_ADDR;
    ptc_trigger_ctrl #(.UNITS(4)) dut (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o),
        .time_due_i(time_due_i),
        .time_past_i(time_past_i),
        .trig_o(trig_o),
        .irq_o(irq_o)
    );
    // ****************************************
    // clock, timeout and shared tasks
    // ****************************************
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    // ceiling well above the few hundred cycles the tests need
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_read_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    task automatic ux(input logic [31:0] u, input logic [31:0] d);
        wr(IDX, u);
        wr(CTL, d);
    endtask
    // samples from the current cycle on, so a fire right after start is seen
    task automatic cnt(input int n);
        pc = '{0, 0, 0, 0};
        repeat (n) begin
            #1 for (int i = 0; i < 4; i++) pc[i] += (trig_o[i] === 1'b1);
            @(posedge sys_clk_i);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        rd(IDX, 32'h0);
        rd(CTL, 32'h0);
        wr(CTL, 32'hFFFF_FFFF);
        rd(CTL, 32'hCF80_0000);
        rd(16'h0600, 32'h0);
        ux(32'h1, 32'h0100_0000);
        wr(IDX, 32'h0);
        rd(CTL, 32'hCF80_0000);
        wr(CMD, 32'h4);
        rd(CTL, 32'h0);
        rd(CMD, 32'h0);
        $display("register test done");
    endtask
    task automatic t_wait;
        ux(32'h0, 32'h0100_0000);
        wr(`PTC_IRQ_ENABLE_ADDR, 32'h1);
        wr(CMD, 32'h8);
        cnt(4);
        chk(pc[0], 0);
        rd(CMD, 32'h18);
        @(posedge sys_clk_i);
        time_due_i <= 4'h1;
        cnt(4);
        chk(pc[0], 1);
        rd(CMD, 32'h0);
        rd(STA, 32'h1);
        chk(irq_o, 1);
        wr(STA, 32'h1);
        #1 chk(irq_o, 0);
        $display("wait test done");
    endtask
    task automatic t_now;
        @(posedge sys_clk_i);
        time_due_i <= 4'hE;
        time_past_i <= 4'hE;
        ux(32'h1, 32'h0200_0000);
        wr(CMD, 32'h8);
        cnt(3);
        chk(pc[1], 1);
        chk(pc[2], 0);
        rd(STA, 32'h0);
        wr(CMD, 32'hC);
        cnt(3);
        chk(pc[1], 0);
        wr(CTL, 32'h0100_0000);
        wr(CMD, 32'h8);
        cnt(3);
        chk(pc[1], 0);
        rd(STA, 32'h20);
        wr(`PTC_IRQ_ENABLE_ADDR, 32'h20);
        #1 chk(irq_o, 1);
        wr(STA, 32'h20);
        #1 chk(irq_o, 0);
        $display("trigger now test done");
    endtask
    task automatic t_chain;
        ux(32'h1, 32'h8E00_0000);
        ux(32'h2, 32'h8600_0000);
        ux(32'h3, 32'hCA00_0000);
        wr(IDX, 32'h1);
        wr(CMD, 32'h8);
        cnt(20);
        chk({pc[1][7:0], pc[2][7:0], pc[3][7:0]}, 32'h010101);
        ux(32'h3, 32'h8A00_0000);
        wr(IDX, 32'h1);
        wr(CMD, 32'h8);
        cnt(30);
        chk(pc[1] >= 2 && pc[3] >= 2, 1);
        for (int u = 1; u < 4; u++) begin
            wr(IDX, u);
            wr(CMD, 32'h4);
        end
        cnt(20);
        chk(pc[1] + pc[2] + pc[3], 0);
        $display("cascade test done");
    endtask
    task automatic t_edge;
        logic a;
        logic hit;
        hit = 1'b0;
        ux(32'h2, 32'h0280_0000);
        wr(CMD, 32'h8);
        repeat (4) begin
            #1 a = trig_o[2];
            @(negedge sys_clk_i);
            #1 if (!a && trig_o[2]) hit = 1'b1;
            @(posedge sys_clk_i);
        end
        chk(hit, 1);
        $display("edge test done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_wait();
        t_now();
        t_chain();
        t_edge();
        complete_run();
    end
endmodule // ptc_trigger_ctrl_test
